// ---- include/timer_pkg.sv ----
package timer_pkg;
   // bus geometry
   localparam int ADR_W = 10;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;
   localparam int CNT_W = 8;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_MODE      = 8'h8b;
   localparam logic [7:0] IDX_PRESCALER = 8'h8c;
   localparam logic [7:0] IDX_TIMER     = 8'h8d;
   localparam logic [7:0] IDX_SOURCE    = 8'h8e;
   localparam logic [7:0] IDX_CAPTURE   = 8'h8f;
   localparam logic [7:0] IDX_STATUS    = 8'h90;
   localparam logic [7:0] IDX_MASK      = 8'h91;

   // reset values
   localparam logic [7:0] RELOAD_RST = 8'hff;
   localparam logic [1:0] SOURCE_RST = 2'h0;
   localparam logic [2:0] MODE_RST   = 3'h0;
   localparam logic [1:0] STATUS_RST = 2'h0;
   localparam logic [1:0] MASK_RST   = 2'h0;

   // field positions
   localparam int MODE_LSB  = 0;
   localparam int MODE_W    = 3;
   localparam int POL_BIT   = 3;
   localparam int START_BIT = 7;
   localparam int SRC_LSB   = 0;
   localparam int SRC_W     = 2;
   localparam int ST_UNDER  = 0;
   localparam int ST_EDGE   = 1;
   localparam int ST_W      = 2;

   // internal clock divider
   localparam int         DIV_W    = 3;
   localparam logic [2:0] DIV_LAST = 3'h7;

   typedef enum logic [2:0] {
      MODE_TIMER  = 3'b000,
      MODE_PULSE  = 3'b001,
      MODE_EVENT  = 3'b010,
      MODE_WIDTH  = 3'b011,
      MODE_PERIOD = 3'b100
   } mode_e;

   typedef enum logic [1:0] {
      SRC_F1  = 2'b00,
      SRC_F8  = 2'b01,
      SRC_OSC = 2'b10,
      SRC_F2  = 2'b11
   } source_e;
endpackage

// ---- include/stage_if.sv ----
`timescale 1ns/10ps
interface stage_if;
   logic       tick;
   logic       restart;
   logic       wrEn;
   logic       load;
   logic [7:0] wrData;
   logic [7:0] count;
   logic [7:0] reload;
   logic       underflow;

   modport ctrl (output tick, output restart, output wrEn, output load, output wrData,
                 input count, input reload, input underflow);
   modport stage (input tick, input restart, input wrEn, input load, input wrData,
                  output count, output reload, output underflow);
endinterface

// ---- rtl/stage_counter.sv ----
`timescale 1ns/10ps
module stage_counter (
   input wire logic clk,
   input wire logic rst,
   stage_if.stage   st
);
   import timer_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] reload_q;
   logic [CNT_W-1:0] reload_d;

   // underflow is the tick that finds the counter at zero
   assign st.underflow = st.tick && (cnt_q == '0);
   assign st.count     = cnt_q;
   assign st.reload    = reload_q;

   // next reload and count values
   always_comb begin
      reload_d = st.wrEn ? st.wrData : reload_q;
      cnt_d    = cnt_q;
      if (st.load) begin
         cnt_d = st.wrData;
      end else if (st.restart) begin
         cnt_d = reload_q;
      end else if (st.tick) begin
         if (cnt_q == '0) begin
            cnt_d = reload_q;
         end else begin
            cnt_d = cnt_q - 8'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q    <= RELOAD_RST;
         reload_q <= RELOAD_RST;
      end else begin
         cnt_q    <= cnt_d;
         reload_q <= reload_d;
      end
   end

   a_stage_wrap: assert property (@(posedge clk) disable iff (rst)
      st.underflow && !st.load && !st.restart && !st.wrEn |=> cnt_q == $past(reload_q))
      else $error("stage did not reload after underflow");
   a_stage_step: assert property (@(posedge clk) disable iff (rst)
      st.tick && cnt_q != 8'h00 && !st.load && !st.restart |=> cnt_q == $past(cnt_q) - 8'h01)
      else $error("stage did not decrement on tick");
   c_stage_wrap: cover property (@(posedge clk) disable iff (rst) st.underflow);
endmodule

// ---- rtl/prescaled_reload_timer.sv ----
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
// Functional notes
// - 8-bit timer stage counts underflows of an 8-bit prescaler stage
// - each stage has its own reload register and down-counter
// - reload and live count of a stage share one register address
// - timer mode counts the selected internal source, pin unused
// - pulse output mode toggles the pin at every timer underflow
// - event counter mode counts active edges on the counter pin
// - width mode counts internal source while pin is at active level
// - period mode counts internal source between like active pin edges
// - rewriting edge polarity may set the external interrupt 1 request flag
// - underflow reloads the counter and counting continues, divide (n+1)(m+1)
// - source select: 00 f1, 01 f8, 10 low-speed oscillator, 11 f2
// - counting starts only once the start bit is written 1
module prescaled_reload_timer (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           wb_cyc_i,
   input  wire logic                           wb_stb_i,
   input  wire logic                           wb_we_i,
   input  wire logic [timer_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire logic [timer_pkg::SEL_W-1:0]    wb_sel_i,
   input  wire logic [timer_pkg::DAT_W-1:0]    wb_dat_i,
   output logic      [timer_pkg::DAT_W-1:0]    wb_dat_o,
   output logic                                wb_ack_o,
   input  wire logic                           counterPulsePinIn,
   output logic                                counterPulsePinOut,
   output logic                                counterPulsePinOe,
   input  wire logic                           lowspeedOscClock,
   output logic                                irq
);
   import timer_pkg::*;

   // register state
   logic [MODE_W-1:0] mode_q;
   logic [MODE_W-1:0] mode_d;
   logic              pol_q;
   logic              pol_d;
   logic              start_q;
   logic              start_d;
   logic [SRC_W-1:0]  src_q;
   logic [SRC_W-1:0]  src_d;
   logic [ST_W-1:0]   status_q;
   logic [ST_W-1:0]   status_d;
   logic [ST_W-1:0]   mask_q;
   logic [ST_W-1:0]   mask_d;
   logic [15:0]       cap_q;
   logic [15:0]       cap_d;
   logic              pinOut_q;
   logic              pinOut_d;
   logic              ack_q;
   logic              ack_d;
   logic [DAT_W-1:0]  rdat_q;
   logic [DAT_W-1:0]  rdat_d;

   // synchronisers and edge detection
   logic [2:0]        pinSync_q;
   logic [2:0]        oscSync_q;
   logic [DIV_W-1:0]  div_q;
   logic [DIV_W-1:0]  div_d;

   // decoded bus and timing terms
   logic [7:0]        idx;
   logic              req;
   logic              wbWr;
   logic [7:0]        wdat;
   logic              modeWr;
   mode_e             modeNow;
   logic              srcTick;
   logic              pinLevel;
   logic              pinActive;
   logic              pinEdge;
   logic              presTick;
   logic              measEdge;
   logic              polChange;

   stage_if presIf ();
   stage_if timIf ();

   stage_counter u_prescaler (
      .clk (clk),
      .rst (rst),
      .st  (presIf)
   );

   stage_counter u_timer (
      .clk (clk),
      .rst (rst),
      .st  (timIf)
   );

   // bus decode; a write lands on the edge where the master sees ack
   assign idx     = wb_adr_i[9:2];
   assign req     = wb_cyc_i && wb_stb_i;
   assign wbWr    = req && wb_we_i && ack_q && wb_sel_i[0];
   assign wdat    = wb_dat_i[7:0];
   assign modeWr  = wbWr && (idx == IDX_MODE);
   assign modeNow = mode_e'(mode_q);

   // internal clock source selection
   always_comb begin
      case (source_e'(src_q))
         SRC_F1:  srcTick = 1'b1;
         SRC_F8:  srcTick = (div_q == DIV_LAST);
         SRC_OSC: srcTick = oscSync_q[1] && !oscSync_q[2];
         SRC_F2:  srcTick = div_q[0];
         default: srcTick = 1'b0;
      endcase
   end

   // pin level and active edge after synchronising; polarity 0 is high active
   assign pinLevel  = pinSync_q[1];
   assign pinActive = pinLevel ^ pol_q;
   assign pinEdge   = pinActive && !(pinSync_q[2] ^ pol_q);

   // count event for the prescaler, by mode
   always_comb begin
      case (modeNow)
         MODE_TIMER:  presTick = srcTick;
         MODE_PULSE:  presTick = srcTick;
         MODE_EVENT:  presTick = pinEdge;
         MODE_WIDTH:  presTick = srcTick && pinActive;
         MODE_PERIOD: presTick = srcTick;
         default:     presTick = srcTick;
      endcase
      presTick = presTick && start_q;
   end

   // period mode restarts both stages on each active edge
   assign measEdge  = start_q && pinEdge &&
                      ((modeNow == MODE_PERIOD) || (modeNow == MODE_WIDTH));
   assign polChange = modeWr && (wdat[POL_BIT] != pol_q);

   // stage controls: shared address carries reload write and stopped load
   assign presIf.tick    = presTick;
   assign presIf.restart = measEdge && (modeNow == MODE_PERIOD);
   assign presIf.wrEn    = wbWr && (idx == IDX_PRESCALER);
   assign presIf.load    = presIf.wrEn && !start_q;
   assign presIf.wrData  = wdat;
   assign timIf.tick     = presIf.underflow;
   assign timIf.restart  = presIf.restart;
   assign timIf.wrEn     = wbWr && (idx == IDX_TIMER);
   assign timIf.load     = timIf.wrEn && !start_q;
   assign timIf.wrData   = wdat;

   // control, status and capture next values
   always_comb begin
      mode_d   = mode_q;
      pol_d    = pol_q;
      start_d  = start_q;
      src_d    = src_q;
      mask_d   = mask_q;
      cap_d    = cap_q;
      pinOut_d = pinOut_q;
      status_d = status_q;
      if (modeWr) begin
         mode_d  = wdat[MODE_LSB +: MODE_W];
         pol_d   = wdat[POL_BIT];
         start_d = wdat[START_BIT];
      end
      if (wbWr && idx == IDX_SOURCE) begin
         src_d = wdat[SRC_LSB +: SRC_W];
      end
      if (wbWr && idx == IDX_MASK) begin
         mask_d = wdat[ST_W-1:0];
      end
      if (wbWr && idx == IDX_STATUS) begin
         status_d = status_q & ~wdat[ST_W-1:0];
      end
      if (measEdge && modeNow == MODE_PERIOD) begin
         cap_d = {timIf.count, presIf.count};
      end
      if (timIf.underflow && modeNow == MODE_PULSE) begin
         pinOut_d = !pinOut_q;
      end
      // hardware set wins over a software clear in the same cycle
      if (timIf.underflow) begin
         status_d[ST_UNDER] = 1'b1;
      end
      if (polChange || measEdge) begin
         status_d[ST_EDGE] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q   <= MODE_RST;
         pol_q    <= 1'b0;
         start_q  <= 1'b0;
         src_q    <= SOURCE_RST;
         mask_q   <= MASK_RST;
         status_q <= STATUS_RST;
         cap_q    <= '0;
         pinOut_q <= 1'b0;
      end else begin
         mode_q   <= mode_d;
         pol_q    <= pol_d;
         start_q  <= start_d;
         src_q    <= src_d;
         mask_q   <= mask_d;
         status_q <= status_d;
         cap_q    <= cap_d;
         pinOut_q <= pinOut_d;
      end
   end

   // divider for f2 and f8, and pin synchronisers
   assign div_d = div_q + 3'h1;

   always_ff @(posedge clk) begin
      if (rst) begin
         div_q     <= '0;
         pinSync_q <= '0;
         oscSync_q <= '0;
      end else begin
         div_q     <= div_d;
         pinSync_q <= {pinSync_q[1:0], counterPulsePinIn};
         oscSync_q <= {oscSync_q[1:0], lowspeedOscClock};
      end
   end

   // read mux and single-cycle acknowledge
   always_comb begin
      ack_d  = req && !ack_q;
      rdat_d = '0;
      case (idx)
         IDX_MODE:      rdat_d[7:0] = {start_q, 3'h0, pol_q, mode_q};
         IDX_PRESCALER: rdat_d[7:0] = presIf.count;
         IDX_TIMER:     rdat_d[7:0] = timIf.count;
         IDX_SOURCE:    rdat_d[7:0] = {6'h00, src_q};
         IDX_CAPTURE:   rdat_d[15:0] = cap_q;
         IDX_STATUS:    rdat_d[7:0] = {6'h00, status_q};
         IDX_MASK:      rdat_d[7:0] = {6'h00, mask_q};
         default:       rdat_d = '0;
      endcase
      if (!ack_d) begin
         rdat_d = rdat_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q  <= 1'b0;
         rdat_q <= '0;
      end else begin
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o           = ack_q;
   assign wb_dat_o           = rdat_q;
   assign irq                = |(status_q & mask_q);
   assign counterPulsePinOut = pinOut_q;
   assign counterPulsePinOe  = (modeNow == MODE_PULSE);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_ack_answer: assert property (req && !ack_q |=> ack_q)
      else $error("no acknowledge one cycle after request");
   a_ack_single: assert property (ack_q |=> !ack_q)
      else $error("acknowledge held longer than one cycle");
   a_stop_idle: assert property (!start_q |-> !presIf.tick && !timIf.underflow)
      else $error("counting while stopped");
   a_event_pin: assert property (modeNow == MODE_EVENT && presIf.tick |-> pinEdge)
      else $error("event count without pin edge");
   a_width_gate: assert property (modeNow == MODE_WIDTH && presIf.tick |-> pinActive)
      else $error("width count outside active level");
   a_under_flag: assert property (timIf.underflow |=> status_q[ST_UNDER])
      else $error("underflow flag not set");
   a_pulse_toggle: assert property (
      modeNow == MODE_PULSE && timIf.underflow |=> counterPulsePinOut != $past(pinOut_q))
      else $error("pulse pin did not toggle on underflow");
   a_polarity_flag: assert property (polChange |=> status_q[ST_EDGE])
      else $error("polarity rewrite did not flag");
   a_timer_clock: assert property (timIf.tick |=> presIf.count == $past(presIf.reload))
      else $error("timer ticked without prescaler underflow");
   a_stopped_load: assert property (timIf.wrEn && !start_q |=> timIf.count == $past(wdat))
      else $error("stopped write did not load counter");
   // period restart and capture, f1 source rate, write-one clear of the underflow flag
   a_period_restart: assert property (measEdge && modeNow == MODE_PERIOD |=>
      presIf.count == $past(presIf.reload) && timIf.count == $past(timIf.reload))
      else $error("period edge did not restart both stages");
   a_capture_take: assert property (measEdge && modeNow == MODE_PERIOD |=>
      cap_q == {$past(timIf.count), $past(presIf.count)})
      else $error("period edge did not capture counts");
   a_f1_source: assert property (start_q && src_q == SRC_F1 && modeNow == MODE_TIMER |->
      presIf.tick)
      else $error("f1 source did not tick every clock");
   a_status_clear: assert property (wbWr && idx == IDX_STATUS && wdat[ST_UNDER] &&
      !timIf.underflow |=> !status_q[ST_UNDER])
      else $error("status write one did not clear");

   c_pulse_out: cover property (modeNow == MODE_PULSE && timIf.underflow);
   c_period_cap: cover property (measEdge && modeNow == MODE_PERIOD);
   c_irq_rise: cover property (!irq ##1 irq);
   c_width_count: cover property (modeNow == MODE_WIDTH && presIf.tick);
endmodule

// ---- verification/pulse_partner.sv ----
`timescale 1ns/10ps
module pulse_partner (
   input  wire logic clk,
   input  wire logic pinOut,
   output logic      pinDrive,
   output int        lastGap,
   output int        toggles
);
   int   gap = 0;
   logic prevOut = 1'b0;

   // the pin idles low between bursts
   initial begin
      pinDrive = 1'b0;
   end

   // consumer side: time the gap between output toggles
   always @(posedge clk) begin
      prevOut <= pinOut;
      gap <= gap + 1;
      if (pinOut !== prevOut) begin
         lastGap <= gap;
         gap <= 1;
         toggles <= toggles + 1;
      end
   end

   // source side: cnt pulses, high for hi clocks then low for lo clocks
   task automatic pulses(input int hi, input int lo, input int cnt);
      repeat (cnt) begin
         @(posedge clk);
         pinDrive <= 1'b1;
         repeat (hi) @(posedge clk);
         pinDrive <= 1'b0;
         repeat (lo - 1) @(posedge clk);
      end
   endtask
endmodule

// ---- verification/prescaled_reload_timer_tb.sv ----
`timescale 1ns/10ps
module prescaled_reload_timer_tb;
   import timer_pkg::*;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             cyc = 1'b0;
   logic             stb = 1'b0;
   logic             we = 1'b0;
   logic [ADR_W-1:0] adr = '0;
   logic [DAT_W-1:0] dato = '0;
   logic [DAT_W-1:0] dati;
   logic             ack;
   logic             pinOut;
   logic             pinOe;
   logic             pinDrive;
   logic             irq;
   logic             osc = 1'b0;
   logic [31:0]      q;
   int               oscCnt = 0;
   int               fail_count = 0;
   int               checks_done = 0;
   int               seed = 76183;
   int               lastGap;
   int               toggles;
   int               n, m, p, t, base;
   int               tick[4] = '{1, 8, 10, 2};
   logic [7:0]       rIdx[$] = '{IDX_MODE, IDX_PRESCALER, IDX_TIMER, IDX_SOURCE,
                                 IDX_STATUS, IDX_MASK};
   logic [7:0]       rExp[$] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

   always #10 clk = ~clk;

   // slow oscillator: one rising edge every ten clocks
   always @(posedge clk) begin
      oscCnt <= (oscCnt == 4) ? 0 : oscCnt + 1;
      if (oscCnt == 4) osc <= ~osc;
   end

   prescaled_reload_timer i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dato), .wb_dat_o(dati),
      .wb_ack_o(ack), .counterPulsePinIn(pinOe ? pinOut : pinDrive),
      .counterPulsePinOut(pinOut), .counterPulsePinOe(pinOe), .lowspeedOscClock(osc),
      .irq(irq));
   pulse_partner i_partner (.clk(clk), .pinOut(pinOut), .pinDrive(pinDrive),
      .lastGap(lastGap), .toggles(toggles));

   task automatic results;
      if (fail_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   // one clock of slack where a synchroniser edge may land either side
   task automatic near(string nm, logic [7:0] e, logic [7:0] g);
      checks_done++;
      if (g !== e && g !== e + 8'h01) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   // classic single cycle, request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      dato <= {24'h0, d};
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      q = dati;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 20) begin
         chk("bus ack", 1, 0);
         results();
      end
   endtask

   function automatic logic [7:0] md(logic go, logic pol, mode_e mo);
      return {go, 3'h0, pol, mo};
   endfunction

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         wb(0, rIdx[i], 0);
         chk("reset value", rExp[i], q);
      end
      wb(1, 8'h80, 8'h5a);
      wb(0, 8'h80, 0);
      chk("unmapped", 0, q);
      // a stopped stage keeps what was written
      wb(1, IDX_PRESCALER, 8'h00);
      wb(1, IDX_TIMER, 8'h33);
      repeat (20) @(posedge clk);
      wb(0, IDX_TIMER, 0);
      chk("stopped timer", 8'h33, q);
      // pulse output period for every count source
      for (int s = 0; s < 4; s++) begin
         n = $random(seed) & 3;
         m = $random(seed) & 3;
         wb(1, IDX_MODE, md(0, 0, MODE_PULSE));
         wb(1, IDX_PRESCALER, n[7:0]);
         wb(1, IDX_TIMER, m[7:0]);
         wb(1, IDX_SOURCE, s[7:0]);
         wb(1, IDX_MODE, md(1, 0, MODE_PULSE));
         base = toggles;
         for (int k = 0; toggles < base + 3; k++) begin
            if (k > 3000) begin
               chk("toggle wait", 1, 0);
               results();
            end
            @(posedge clk);
         end
         chk("toggle gap", tick[s] * (n + 1) * (m + 1), lastGap);
         chk("pin enable", 1, pinOe);
      end
      wb(1, IDX_MODE, md(0, 0, MODE_PULSE));
      wb(1, IDX_SOURCE, SRC_F1);
      // sticky underflow flag, mask and write-one clear
      wb(0, IDX_STATUS, 0);
      chk("status", 8'h01, q);
      chk("irq masked", 0, irq);
      wb(1, IDX_MASK, 8'h03);
      @(posedge clk);
      chk("irq", 1, irq);
      wb(1, IDX_STATUS, 8'h01);
      wb(0, IDX_STATUS, 0);
      chk("status cleared", 0, q);
      chk("irq cleared", 0, irq);
      wb(1, IDX_MODE, md(0, 1, MODE_TIMER));
      wb(0, IDX_STATUS, 0);
      chk("edge request", 8'h02, q);
      chk("pin released", 0, pinOe);
      // plain timer mode on f1: start, then stop 43 count edges later
      n = $random(seed) & 7;
      wb(1, IDX_PRESCALER, n[7:0]);
      wb(1, IDX_TIMER, 8'h40);
      wb(1, IDX_MODE, md(1, 1, MODE_TIMER));
      repeat (40) @(posedge clk);
      wb(1, IDX_MODE, md(0, 1, MODE_TIMER));
      p = n;
      t = 64;
      repeat (43) if (p == 0) begin
         p = n;
         t--;
      end else p--;
      wb(0, IDX_PRESCALER, 0);
      chk("timer prescaler", p, q);
      wb(0, IDX_TIMER, 0);
      chk("timer count", t, q);
      wb(1, IDX_MODE, md(0, 0, MODE_EVENT));
      wb(1, IDX_STATUS, 8'h03);
      // pin events through the prescaler into the timer
      wb(1, IDX_PRESCALER, 8'h01);
      wb(1, IDX_TIMER, 8'h10);
      wb(1, IDX_MODE, md(1, 0, MODE_EVENT));
      i_partner.pulses(4, 4, 5);
      repeat (6) @(posedge clk);
      p = 1;
      t = 16;
      repeat (5) if (p == 0) begin
         p = 1;
         t--;
      end else p--;
      wb(0, IDX_PRESCALER, 0);
      chk("event prescaler", p, q);
      wb(0, IDX_TIMER, 0);
      chk("event timer", t, q);
      // width: counts only while the pin is high
      wb(1, IDX_MODE, md(0, 0, MODE_WIDTH));
      wb(1, IDX_PRESCALER, 8'hff);
      wb(1, IDX_TIMER, 8'hff);
      wb(1, IDX_MODE, md(1, 0, MODE_WIDTH));
      repeat (10) @(posedge clk);
      wb(0, IDX_PRESCALER, 0);
      chk("width idle", 8'hff, q);
      i_partner.pulses(12, 6, 1);
      repeat (6) @(posedge clk);
      wb(0, IDX_PRESCALER, 0);
      near("width count", 8'hff - 8'd12, q[7:0]);
      // period: capture between rising edges twenty clocks apart
      wb(1, IDX_MODE, md(0, 0, MODE_PERIOD));
      wb(1, IDX_MODE, md(1, 0, MODE_PERIOD));
      i_partner.pulses(10, 10, 3);
      repeat (6) @(posedge clk);
      wb(0, IDX_CAPTURE, 0);
      chk("capture timer", 8'hff, q[15:8]);
      near("capture prescaler", 8'hff - 8'd20, q[7:0]);
      results();
   end

   initial begin
      repeat (100000) @(posedge clk);
      chk("run time", 1, 0);
      results();
   end
endmodule
